// ---- hw/timer16_compare_capture_regs.sv ----
// Two 16-bit timers: counter, compare, capture and shared high-byte latch behind an 8-bit CPU port
// Behaviour
// - The CPU reads and writes the 16-bit count value through a low-byte and a high-byte location.
// - Both bytes of a count access move together, the upper byte staged in an 8-bit latch.
// - A single high-byte latch serves writes to every 16-bit register of both timers, and count and capture reads.
// - A CPU write to a count value blocks any compare match on that timer's next timer clock.
// - Each 16-bit compare value is checked against the count on every timer clock not blocked by a count write.
// - A compare value write commits both bytes at once through the shared latch.
// - The capture value loads the count on each capture pin event, or for timer 1 the comparator.
// - The capture value may serve as the count's top value when selected.
// - Capture value reads return both bytes consistently through the shared latch.
// - Enable bit 7 gates the timer 1 overflow interrupt with the global flag and overflow flag.
// - Enable bit 6 gates the timer 1 compare-A interrupt with the global flag and compare-A flag.
// - The timer 1 overflow flag clears on vector execution or on a written one.
// - The capture edge select picks falling edge when zero and rising edge when one.
// - While capture is the top value the capture pin is ignored and capture is disabled.
`default_nettype none
module timer16_compare_capture_regs
  import timer16_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // CPU register port
  input wire logic CPU_RD,
  input wire logic CPU_WR,
  input wire logic [4:0] CPU_ADDR,
  input wire logic [7:0] CPU_WDATA,
  output logic [7:0] CPU_RDATA,
  // Timer clock enables, one-cycle pulses
  input wire logic T1_TICK,
  input wire logic T3_TICK,
  // Capture sources
  input wire logic T1_CAPTURE_PIN,
  input wire logic T3_CAPTURE_PIN,
  input wire logic ANALOG_COMPARE_OUT,
  // Interrupt handshake
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic T1_OVF_VECTOR_ACK,
  input wire logic T1_CMPA_VECTOR_ACK,
  output logic T1_OVF_IRQ,
  output logic T1_CMPA_IRQ,
  // Compare match strobes toward waveform logic
  output logic [1:0] T1_MATCH,
  output logic [1:0] T3_MATCH
);

  cpu_req_t req;
  timer_regs_t t1, t3, next_t1, next_t3;
  logic [7:0] high_latch, next_high_latch;
  logic [7:0] irq_en, next_irq_en;
  logic [7:0] flags, next_flags;
  logic [1:0] block, next_block;
  logic [1:0] pin_prev, next_pin_prev;
  logic [1:0] t1_match, t3_match, next_t1_match, next_t3_match;
  logic [7:0] rdata, next_rdata;
  logic w1, w3;

  assign req = '{rd: CPU_RD, wr: CPU_WR, addr: CPU_ADDR, wdata: CPU_WDATA};

  // Edge detect on the chosen capture source; inputs are taken as synchronous
  function automatic logic capt_event(input logic prev, input logic now, input logic rising);
    capt_event = rising ? (!prev && now) : (prev && !now);
  endfunction

  function automatic logic [7:0] byte_of(input logic [15:0] v, input logic hi);
    byte_of = hi ? v[15:8] : v[7:0];
  endfunction

  // Per-timer next-state: count, compare writes, capture, suppression
  function automatic timer_regs_t step(input timer_regs_t cur, input cpu_req_t r, input logic [4:0] base,
                                       input logic [7:0] latch, input logic tick, input logic cap_ev,
                                       output logic wrote_count);
    timer_regs_t n;
    n = cur;
    wrote_count = 1'b0;
    if (tick) begin
      // Capture as top: wrap after reaching it, otherwise free run to max
      if (cur.ctrl[BIT_CAPT_TOP] && cur.count == cur.capt) begin
        n.count = RESET_VALUE16;
      end else begin
        n.count = cur.count + 16'h0001;
      end
    end
    if (cap_ev && !cur.ctrl[BIT_CAPT_TOP]) begin
      n.capt = cur.count;
    end
    if (r.wr) begin
      // Low-byte write commits the staged high byte in the same cycle
      if (r.addr == base) begin
        n.count = {latch, r.wdata};
        wrote_count = 1'b1;
      end
      if (r.addr == base + 5'h02) begin
        n.cmp_a = {latch, r.wdata};
      end
      if (r.addr == base + 5'h04) begin
        n.cmp_b = {latch, r.wdata};
      end
      if (r.addr == base + 5'h06) begin
        n.capt = {latch, r.wdata};
      end
    end
    return n;
  endfunction

  // Timer registers, shared high-byte latch and read data
  always_comb begin
    logic ev1, ev3, src1;
    logic [4:0] a;
    ev1 = 1'b0;
    ev3 = 1'b0;
    src1 = 1'b0;
    w1 = 1'b0;
    w3 = 1'b0;
    a = req.addr;
    src1 = t1.ctrl[BIT_T1_CAPT_ANALOG] ? ANALOG_COMPARE_OUT : T1_CAPTURE_PIN;
    ev1 = capt_event(pin_prev[0], src1, t1.ctrl[BIT_CAPT_EDGE]);
    ev3 = capt_event(pin_prev[1], T3_CAPTURE_PIN, t3.ctrl[BIT_CAPT_EDGE]);
    next_pin_prev = {T3_CAPTURE_PIN, src1};
    next_t1 = step(t1, req, ADDR_T1_COUNT_LO, high_latch, T1_TICK, ev1, w1);
    next_t3 = step(t3, req, ADDR_T3_COUNT_LO, high_latch, T3_TICK, ev3, w3);
    next_high_latch = high_latch;
    next_rdata = rdata;
    if (req.wr) begin
      case (a)
        ADDR_T1_COUNT_HI, ADDR_T1_CMPA_HI, ADDR_T1_CMPB_HI, ADDR_T1_CAPT_HI,
        ADDR_T3_COUNT_HI, ADDR_T3_CMPA_HI, ADDR_T3_CMPB_HI, ADDR_T3_CAPT_HI: begin
          next_high_latch = req.wdata;
        end
        ADDR_T1_CTRL: begin
          next_t1.ctrl = req.wdata;
        end
        ADDR_T3_CTRL: begin
          next_t3.ctrl = req.wdata;
        end
        default: begin
        end
      endcase
    end
    if (req.rd) begin
      case (a)
        // Count and capture low reads snapshot the high byte so a later high read matches
        ADDR_T1_COUNT_LO: begin
          next_rdata = byte_of(t1.count, 1'b0);
          next_high_latch = byte_of(t1.count, 1'b1);
        end
        ADDR_T1_CMPA_LO: begin
          next_rdata = byte_of(t1.cmp_a, 1'b0);
        end
        ADDR_T1_CMPB_LO: begin
          next_rdata = byte_of(t1.cmp_b, 1'b0);
        end
        ADDR_T1_CAPT_LO: begin
          next_rdata = byte_of(t1.capt, 1'b0);
          next_high_latch = byte_of(t1.capt, 1'b1);
        end
        ADDR_T3_COUNT_LO: begin
          next_rdata = byte_of(t3.count, 1'b0);
          next_high_latch = byte_of(t3.count, 1'b1);
        end
        ADDR_T3_CMPA_LO: begin
          next_rdata = byte_of(t3.cmp_a, 1'b0);
        end
        ADDR_T3_CMPB_LO: begin
          next_rdata = byte_of(t3.cmp_b, 1'b0);
        end
        ADDR_T3_CAPT_LO: begin
          next_rdata = byte_of(t3.capt, 1'b0);
          next_high_latch = byte_of(t3.capt, 1'b1);
        end
        // Compare values are CPU-owned, so their high byte reads directly
        ADDR_T1_CMPA_HI: begin
          next_rdata = byte_of(t1.cmp_a, 1'b1);
        end
        ADDR_T1_CMPB_HI: begin
          next_rdata = byte_of(t1.cmp_b, 1'b1);
        end
        ADDR_T3_CMPA_HI: begin
          next_rdata = byte_of(t3.cmp_a, 1'b1);
        end
        ADDR_T3_CMPB_HI: begin
          next_rdata = byte_of(t3.cmp_b, 1'b1);
        end
        ADDR_T1_COUNT_HI, ADDR_T1_CAPT_HI, ADDR_T3_COUNT_HI, ADDR_T3_CAPT_HI: begin
          next_rdata = high_latch;
        end
        ADDR_TIMER_IRQ_EN: begin
          next_rdata = irq_en;
        end
        ADDR_TIMER_FLAGS: begin
          next_rdata = flags;
        end
        ADDR_T1_CTRL: begin
          next_rdata = t1.ctrl;
        end
        ADDR_T3_CTRL: begin
          next_rdata = t3.ctrl;
        end
        // Unmapped reads return zero
        default: begin
          next_rdata = RESET_VALUE8;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      t1 <= '0;
      t3 <= '0;
      high_latch <= RESET_VALUE8;
      pin_prev <= 2'b00;
      rdata <= RESET_VALUE8;
    end else begin
      t1 <= next_t1;
      t3 <= next_t3;
      high_latch <= next_high_latch;
      pin_prev <= next_pin_prev;
      rdata <= next_rdata;
    end
  end

  // Compare units; a count write arms a block for one timer clock
  always_comb begin
    next_t1_match = 2'b00;
    next_t3_match = 2'b00;
    next_block = {block[1] | w3, block[0] | w1};
    if (T1_TICK) begin
      next_block[0] = w1;
      if (!block[0]) begin
        next_t1_match = {t1.count == t1.cmp_b, t1.count == t1.cmp_a};
      end
    end
    if (T3_TICK) begin
      next_block[1] = w3;
      if (!block[1]) begin
        next_t3_match = {t3.count == t3.cmp_b, t3.count == t3.cmp_a};
      end
    end
  end

  // Registered, so the compare flag follows the match pulse by one clock
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      block <= 2'b00;
      t1_match <= 2'b00;
      t3_match <= 2'b00;
    end else begin
      block <= next_block;
      t1_match <= next_t1_match;
      t3_match <= next_t3_match;
    end
  end

  // Interrupt enables and flags
  always_comb begin
    next_irq_en = irq_en;
    next_flags = flags;
    if (req.wr && req.addr == ADDR_TIMER_IRQ_EN) begin
      next_irq_en = req.wdata;
    end

    // Clears first so a same-cycle set wins
    if (req.wr && req.addr == ADDR_TIMER_FLAGS) begin
      next_flags = flags & ~req.wdata;
    end
    // Vector acks are one pulse each from the core
    if (T1_OVF_VECTOR_ACK) begin
      next_flags[BIT_T1_OVF] = 1'b0;
    end
    if (T1_CMPA_VECTOR_ACK) begin
      next_flags[BIT_T1_CMPA] = 1'b0;
    end
    // No overflow in capture-as-top mode, even when the count runs through max and wraps
    if (T1_TICK && !t1.ctrl[BIT_CAPT_TOP] && t1.count == COUNT_MAX) begin
      next_flags[BIT_T1_OVF] = 1'b1;
    end
    if (t1_match[0]) begin
      next_flags[BIT_T1_CMPA] = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_en <= RESET_VALUE8;
      flags <= RESET_VALUE8;
    end else begin
      irq_en <= next_irq_en;
      flags <= next_flags;
    end
  end

  // Interrupt requests are combinational, so a cleared flag drops them at once

  assign CPU_RDATA = rdata;
  assign T1_MATCH = t1_match;
  assign T3_MATCH = t3_match;
  assign T1_OVF_IRQ = GLOBAL_IRQ_ENABLE & irq_en[BIT_T1_OVF] & flags[BIT_T1_OVF];
  assign T1_CMPA_IRQ = GLOBAL_IRQ_ENABLE & irq_en[BIT_T1_CMPA] & flags[BIT_T1_CMPA];

endmodule // timer16_compare_capture_regs
`default_nettype wire

// ---- hw/timer16_pkg.sv ----
// Package for the 16-bit timer register block: addresses, field positions, resets, bus carriers
`default_nettype none
package timer16_pkg;
  // Register addresses on the 8-bit CPU port (device-local, per timer: 1 and 3)
  localparam logic [4:0] ADDR_T1_COUNT_LO = 5'h00;
  localparam logic [4:0] ADDR_T1_COUNT_HI = 5'h01;
  localparam logic [4:0] ADDR_T1_CMPA_LO = 5'h02;
  localparam logic [4:0] ADDR_T1_CMPA_HI = 5'h03;
  localparam logic [4:0] ADDR_T1_CMPB_LO = 5'h04;
  localparam logic [4:0] ADDR_T1_CMPB_HI = 5'h05;
  localparam logic [4:0] ADDR_T1_CAPT_LO = 5'h06;
  localparam logic [4:0] ADDR_T1_CAPT_HI = 5'h07;
  localparam logic [4:0] ADDR_T3_COUNT_LO = 5'h08;
  localparam logic [4:0] ADDR_T3_COUNT_HI = 5'h09;
  localparam logic [4:0] ADDR_T3_CMPA_LO = 5'h0a;
  localparam logic [4:0] ADDR_T3_CMPA_HI = 5'h0b;
  localparam logic [4:0] ADDR_T3_CMPB_LO = 5'h0c;
  localparam logic [4:0] ADDR_T3_CMPB_HI = 5'h0d;
  localparam logic [4:0] ADDR_T3_CAPT_LO = 5'h0e;
  localparam logic [4:0] ADDR_T3_CAPT_HI = 5'h0f;
  localparam logic [4:0] ADDR_TIMER_IRQ_EN = 5'h10;
  localparam logic [4:0] ADDR_TIMER_FLAGS = 5'h11;
  localparam logic [4:0] ADDR_T1_CTRL = 5'h12;
  localparam logic [4:0] ADDR_T3_CTRL = 5'h13;

  // Interrupt enable / flag bit positions
  localparam int BIT_T1_OVF = 7;
  localparam int BIT_T1_CMPA = 6;
  // Control register fields
  localparam int BIT_CAPT_EDGE = 6;
  localparam int BIT_CAPT_TOP = 1;
  localparam int BIT_T1_CAPT_ANALOG = 0;

  localparam logic [15:0] RESET_VALUE16 = 16'h0000;
  localparam logic [7:0] RESET_VALUE8 = 8'h00;
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [7:0] wdata;
  } cpu_req_t;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] capt;
    logic [7:0] ctrl;
  } timer_regs_t;
endpackage
`default_nettype wire

// ---- bench/cpu_port_model.sv ----
// CPU core model: issues one 8-bit register cycle per call
`default_nettype none
module cpu_port_model
  import timer16_pkg::*;
(
  // Clock
  input wire logic clk,
  // Register port
  output cpu_req_t req,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req = '0;
  // Held a full cycle; next call overrides, so no strobe is set twice in one step
  task automatic step(input logic rd, input logic wr, input logic [4:0] a, input logic [7:0] d);
    req = '{rd: rd, wr: wr, addr: a, wdata: d};
    @(posedge clk);
    #1;
  endtask
endmodule // cpu_port_model
`default_nettype wire

// ---- bench/timer16_compare_capture_regs_assertions.sv ----
// Port checker for the timer register block
`default_nettype none
module timer16_compare_capture_regs_assertions
  import timer16_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // CPU port
  input wire logic CPU_RD,
  input wire logic CPU_WR,
  input wire logic [4:0] CPU_ADDR,
  input wire logic [7:0] CPU_RDATA,
  // Timer and interrupts
  input wire logic T1_TICK,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic T1_OVF_VECTOR_ACK,
  input wire logic T1_CMPA_VECTOR_ACK,
  input wire logic T1_OVF_IRQ,
  input wire logic T1_CMPA_IRQ,
  input wire logic [1:0] T1_MATCH
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  AST_RDATA_HOLDS: assert property (!CPU_RD |=> $stable(CPU_RDATA))
    else $error("read data moved without a read");
  AST_OVF_IRQ_GATED: assert property (T1_OVF_IRQ |-> GLOBAL_IRQ_ENABLE)
    else $error("overflow interrupt without global enable");
  AST_CMPA_IRQ_GATED: assert property (T1_CMPA_IRQ |-> GLOBAL_IRQ_ENABLE)
    else $error("compare interrupt without global enable");
  AST_MATCH_ON_TICK: assert property (T1_MATCH != 2'b00 |-> $past(T1_TICK))
    else $error("match without a timer clock");
  AST_WRITE_BLOCKS: assert property (CPU_WR && CPU_ADDR == ADDR_T1_COUNT_LO ##1 T1_TICK |=> T1_MATCH == 2'b00)
    else $error("match not blocked after count write");
  AST_OVF_ACK_CLEARS: assert property (T1_OVF_VECTOR_ACK && !T1_TICK |=> !T1_OVF_IRQ)
    else $error("overflow flag survived its vector");
  AST_CMPA_ACK_CLEARS: assert property (T1_CMPA_VECTOR_ACK && T1_MATCH[0] == 1'b0 |=> !T1_CMPA_IRQ)
    else $error("compare flag survived its vector");
  AST_CMPA_RISE_CAUSE: assert property ($rose(T1_CMPA_IRQ) |-> $past(T1_MATCH[0]) || $past(CPU_WR)
    || $rose(GLOBAL_IRQ_ENABLE)) else $error("compare interrupt rose without cause");
endmodule // timer16_compare_capture_regs_assertions
bind timer16_compare_capture_regs timer16_compare_capture_regs_assertions chk_i (.CORE_CLK, .RST_B, .CPU_RD,
  .CPU_WR, .CPU_ADDR, .CPU_RDATA, .T1_TICK, .GLOBAL_IRQ_ENABLE, .T1_OVF_VECTOR_ACK, .T1_CMPA_VECTOR_ACK,
  .T1_OVF_IRQ, .T1_CMPA_IRQ, .T1_MATCH);
`default_nettype wire

// ---- bench/timer16_compare_capture_regs_test.sv ----
// Self-checking bench for the timer register block
`default_nettype none
module timer16_compare_capture_regs_test
  import timer16_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_b = 1'b0, t1_tick = 1'b0, cap1 = 1'b0, ana = 1'b0, gie = 1'b0;
  logic ack_ovf = 1'b0, ack_cmpa = 1'b0, ovf_irq, cmpa_irq, m_blk = 1'b0;
  logic [1:0] m1, m3, e1, e3;
  logic [7:0] rdata, got;
  logic [15:0] v, m_cnt = 16'h0000, m_cmp = 16'h0000, m_cap = 16'h0000;
  logic [15:0] m_cmpb = 16'h0000, m3_cnt = 16'h0000;
  cpu_req_t req;
  int err_total = 0, checks_done = 0, seed = 1, i;
  always #25 clk = ~clk;
  cpu_port_model cpu (.clk(clk), .req(req), .rdata(rdata));
  timer16_compare_capture_regs dut (.CORE_CLK(clk), .RST_B(rst_b), .CPU_RD(req.rd), .CPU_WR(req.wr),
    .CPU_ADDR(req.addr), .CPU_WDATA(req.wdata), .CPU_RDATA(rdata), .T1_TICK(t1_tick), .T3_TICK(t1_tick),
    .T1_CAPTURE_PIN(cap1), .T3_CAPTURE_PIN(1'b0), .ANALOG_COMPARE_OUT(ana), .GLOBAL_IRQ_ENABLE(gie),
    .T1_OVF_VECTOR_ACK(ack_ovf), .T1_CMPA_VECTOR_ACK(ack_cmpa), .T1_OVF_IRQ(ovf_irq),
    .T1_CMPA_IRQ(cmpa_irq), .T1_MATCH(m1), .T3_MATCH(m3));
  task automatic wrap_up;
    if (err_total == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) cpu.step(1'b0, 1'b0, 5'h00, 8'h00);
  endtask
  task automatic rd8(input logic [4:0] a, output logic [7:0] d);
    cpu.step(1'b1, 1'b0, a, 8'h00);
    d = rdata;
  endtask
  // High byte first, low byte commits
  task automatic wr16(input logic [4:0] a, input logic [15:0] d);
    cpu.step(1'b0, 1'b1, a + 5'h01, d[15:8]);
    cpu.step(1'b0, 1'b1, a, d[7:0]);
    if (a == ADDR_T1_COUNT_LO) {m_blk, m_cnt} = {1'b1, d};
    if (a == ADDR_T1_CMPA_LO) m_cmp = d;
    if (a == ADDR_T1_CMPB_LO) m_cmpb = d;
    if (a == ADDR_T1_CAPT_LO) m_cap = d;
  endtask
  task automatic chk16(input logic [4:0] a, input logic [15:0] e);
    rd8(a, got);
    chk(got, e[7:0]);
    rd8(a + 5'h01, got);
    chk(got, e[15:8]);
  endtask
  task automatic tick(input int n);
    t1_tick = 1'b1;
    repeat (n) begin
      e1 = {m_cnt == m_cmpb, m_cnt == m_cmp} & {2{!m_blk}};
      // Timer 3 shares the tick; its compare values stay at reset zero
      e3 = {2{m3_cnt == 16'h0000}};
      {m_blk, m_cnt, m3_cnt} = {1'b0, m_cnt + 16'h0001, m3_cnt + 16'h0001};
      cpu.step(1'b0, 1'b0, 5'h00, 8'h00);
      chk({6'h00, m1}, {6'h00, e1});
      chk({6'h00, m3}, {6'h00, e3});
    end
    t1_tick = 1'b0;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    wrap_up();
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 rst_b = 1'b1;
    for (i = 0; i < 4; i++) chk16(i < 2 ? 5'h02 + 5'(2 * i) : 5'h06 + 5'(2 * i), 16'h0000);
    rd8(ADDR_TIMER_IRQ_EN, got);
    chk(got, 8'h00);
    rd8(5'h1f, got);
    chk(got, 8'h00);
    for (i = 0; i < 4; i++) begin
      v = 16'($random(seed));
      wr16(5'(2 * i), v);
      chk16(5'(2 * i), v);
    end
    // Lone high write to one register, low write to another: one latch between them
    cpu.step(1'b0, 1'b1, ADDR_T1_CMPA_HI, 8'h5a);
    cpu.step(1'b0, 1'b1, ADDR_T1_COUNT_LO, 8'hc3);
    chk16(ADDR_T1_COUNT_LO, 16'h5ac3);
    chk16(ADDR_T1_CMPA_LO, m_cmp);
    wr16(ADDR_T1_CMPA_LO, 16'h0105);
    cpu.step(1'b0, 1'b1, ADDR_TIMER_IRQ_EN, 8'hc0);
    gie = 1'b1;
    // Count changed only while stopped; each write blocks the next tick, so only the third tick after 0x0103 matches
    wr16(ADDR_T1_COUNT_LO, 16'h0105);
    tick(1);
    wr16(ADDR_T1_COUNT_LO, 16'h0103);
    tick(3);
    idle(2);
    chk({7'h00, cmpa_irq}, 8'h01);
    rd8(ADDR_TIMER_FLAGS, got);
    chk(got & 8'hc0, 8'h40);
    gie = 1'b0;
    idle(1);
    chk({7'h00, cmpa_irq}, 8'h00);
    {gie, ack_cmpa} = 2'b11;
    idle(1);
    ack_cmpa = 1'b0;
    idle(1);
    chk({7'h00, cmpa_irq}, 8'h00);
    wr16(ADDR_T1_COUNT_LO, 16'hffff);
    tick(1);
    idle(2);
    chk({7'h00, ovf_irq}, 8'h01);
    cpu.step(1'b0, 1'b1, ADDR_TIMER_IRQ_EN, 8'h40);
    idle(1);
    chk({7'h00, ovf_irq}, 8'h00);
    cpu.step(1'b0, 1'b1, ADDR_TIMER_IRQ_EN, 8'hc0);
    ack_ovf = 1'b1;
    idle(1);
    ack_ovf = 1'b0;
    rd8(ADDR_TIMER_FLAGS, got);
    chk(got & 8'h80, 8'h00);
    wr16(ADDR_T1_COUNT_LO, 16'hffff);
    tick(1);
    idle(2);
    cpu.step(1'b0, 1'b1, ADDR_TIMER_FLAGS, 8'h80);
    idle(1);
    chk({7'h00, ovf_irq}, 8'h00);
    // Modes: pin rising, pin falling, comparator rising, capture as top
    for (i = 0; i < 4; i++) begin
      cpu.step(1'b0, 1'b1, ADDR_T1_CTRL, {1'b0, i != 1, 4'h0, i == 3, i == 2});
      {cap1, ana} = {i == 1, 1'b0};
      idle(3);
      v = 16'($random(seed));
      wr16(ADDR_T1_COUNT_LO, v);
      if (i == 2) ana = 1'b1;
      else cap1 = ~cap1;
      idle(3);
      if (i != 3) m_cap = v;
      chk16(ADDR_T1_CAPT_LO, m_cap);
    end
    rst_b = 1'b0;
    idle(1);
    rst_b = 1'b1;
    chk16(ADDR_T1_COUNT_LO, 16'h0000);
    wrap_up();
  end
endmodule // timer16_compare_capture_regs_test
`default_nettype wire
